// ==== rtl/dcd_pkg.sv ====
// Package: constants, command codes and decode function for the command front end
package dcd_pkg;

  // ------------------------------------------------------------
  // Widths and field positions
  // ------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int AP_BIT = 10;
  localparam int PIN_W = 5 + BANK_W + ADDR_W;
  localparam int DPIN_W = 2 * LANES + DQ_W;
  localparam int BEAT_W = DQ_W + LANES;

  // ------------------------------------------------------------
  // Burst and timing
  // ------------------------------------------------------------
  localparam logic [3:0] BURST_BEATS = 4'h8;
  localparam int CLK_PERIOD_NS = 20;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int LAST_DATA_TO_PRECHARGE_NS = WRITE_RECOVERY_NS;
  localparam int WR_CYC_RAW = (LAST_DATA_TO_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WR_CYC = (WR_CYC_RAW < 1) ? 4'h1 : 4'(WR_CYC_RAW);

  typedef enum logic [4:0] {
    CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
    CMD_PRE, CMD_PREA, CMD_BST, CMD_MODE, CMD_EXT_MODE, CMD_AREF,
    CMD_SREF_ENT, CMD_SREF_EXIT, CMD_PD_ENT, CMD_PD_EXIT, CMD_ILLEGAL
  } dcd_cmd_type;

  // Byte masks are not an argument: they never take part in decoding
  function automatic dcd_cmd_type dcd_decode(input logic cke_prev, input logic cke,
                                             input logic cs_n, input logic ras_n,
                                             input logic cas_n, input logic we_n,
                                             input logic ap, input logic ba0,
                                             input logic in_sref);
    dcd_cmd_type c;
    logic idle;
    idle = cs_n | (ras_n & cas_n & we_n);
    c = CMD_ILLEGAL;
    if (!cke_prev && cke) begin
      c = in_sref ? CMD_SREF_EXIT : CMD_PD_EXIT;
    end else if (!cke_prev) begin
      c = CMD_NOP;
    end else if (!cke && idle) begin
      c = CMD_PD_ENT;
    end else if (cs_n) begin
      c = CMD_DESEL;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACT;
        3'h5: c = ap ? CMD_RDA : CMD_RD;
        3'h4: c = ap ? CMD_WRA : CMD_WR;
        3'h2: c = ap ? CMD_PREA : CMD_PRE;
        3'h6: c = CMD_BST;
        3'h0: c = ba0 ? CMD_EXT_MODE : CMD_MODE;
        3'h1: c = cke ? CMD_AREF : CMD_SREF_ENT;
        default: c = CMD_ILLEGAL;
      endcase
    end
    return c;
  endfunction : dcd_decode

endpackage : dcd_pkg

// ==== rtl/dcd_strm_if.sv ====
// Interface: valid/ready word stream between the front end and its buffer
`timescale 1ns/1ps
interface dcd_strm_if #(parameter int W = 18);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : dcd_strm_if

// ==== rtl/dcd_pair_buf.sv ====
// Module: two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module dcd_pair_buf #(
  parameter int W = 18
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  dcd_strm_if.snk in_s,
  dcd_strm_if.src out_s
);
  import dcd_pkg::*;

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } dcd_buf_st_type;

  dcd_buf_st_type st_ff;
  dcd_buf_st_type nxt_st;
  logic push;
  logic pop;

  assign in_s.ready = (st_ff.cnt != 2'h2);
  assign out_s.valid = (st_ff.cnt != 2'h0);
  assign out_s.data = st_ff.mem[st_ff.rp];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_s.data;
      nxt_st.wp = ~st_ff.wp;
    end
    if (pop) begin
      nxt_st.rp = ~st_ff.rp;
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i || !ce_i);

  a_buf_no_overfill: assert property (st_ff.cnt != 2'h3)
    else $error("buffer count beyond two");
  a_buf_order_kept: assert property (push && st_ff.cnt == 2'h0 && !pop |=> out_s.data == $past(in_s.data))
    else $error("buffered word differs from pushed word");

endmodule : dcd_pair_buf

// ==== rtl/dcd_cmd_front.sv ====
// Module: command decode, precharge select, write byte masking and read strobe drive
`timescale 1ns/1ps
// ------------------------------------------------------------
// How it works
// - Chip select plus three strobes define command
// - High mask on a beat drops that byte
// - Mask sampled on both strobe edges
// - Lower mask owns low byte, upper high
// - Read strobe edge aligned; write strobe captures data
// - Separate lower and upper strobe per byte
// - Mode operand is address plus both banks
// - Last data to precharge equals write recovery
// - Autoprecharge bit high on a precharge selects every bank
// - Byte masks never affect command decoding
// - Byte masks never affect read data
// - Low, high, ignored and driven input levels
// - Chip select high ignores the command
// - Bank select picks the addressed bank
// ------------------------------------------------------------
module dcd_cmd_front (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic ck_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [dcd_pkg::BANK_W-1:0] bank_select_i,
  input wire logic [dcd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dcd_pkg::DQ_W-1:0] dq_i,
  input wire logic lower_data_strobe_i,
  input wire logic upper_data_strobe_i,
  input wire logic lower_byte_mask_i,
  input wire logic upper_byte_mask_i,
  input wire logic [dcd_pkg::DQ_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  input wire logic wr_ready_i,
  output logic cmd_valid_o,
  output dcd_pkg::dcd_cmd_type cmd_o,
  output logic [dcd_pkg::BANK_W-1:0] bank_o,
  output logic [dcd_pkg::ADDR_W-1:0] addr_o,
  output logic all_banks_o,
  output logic [dcd_pkg::BANK_W+dcd_pkg::ADDR_W-1:0] mode_op_o,
  output logic self_refresh_o,
  output logic wr_valid_o,
  output logic [dcd_pkg::DQ_W-1:0] wr_data_o,
  output logic [dcd_pkg::LANES-1:0] wr_keep_o,
  output logic wr_overrun_o,
  output logic wr_recovery_o,
  output logic [dcd_pkg::DQ_W-1:0] dq_o,
  output logic dq_oe_n_o,
  output logic lower_data_strobe_o,
  output logic upper_data_strobe_o
);
  import dcd_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic ck_m;
    logic ck_s;
    logic ck_p;
    logic [PIN_W-1:0] cp_m;
    logic [PIN_W-1:0] cp_s;
    logic [DPIN_W-1:0] dp_m;
    logic [DPIN_W-1:0] dp_s;
    logic [LANES-1:0] dqs_p;
    logic cke_prev;
    logic in_sref;
    logic cmd_vld;
    dcd_cmd_type cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic all_banks;
    logic [3:0] wr_left;
    logic [3:0] recov;
    logic push_vld;
    logic [BEAT_W-1:0] push_dat;
    logic overrun;
    logic [DQ_W-1:0] dq;
    logic oe_n;
    logic [LANES-1:0] dqs;
  } dcd_st_type;

  dcd_st_type st_ff;
  dcd_st_type nxt_st;

  dcd_strm_if #(.W(BEAT_W)) beat_s ();
  dcd_strm_if #(.W(BEAT_W)) word_s ();

  // Synchronised pin views, read only from the second stage onward
  logic ck_rise;
  logic cke_now;
  logic cs_n_now;
  logic ras_n_now;
  logic cas_n_now;
  logic we_n_now;
  logic [BANK_W-1:0] ba_now;
  logic [ADDR_W-1:0] a_now;
  logic [LANES-1:0] dqs_now;
  logic [LANES-1:0] dm_now;
  logic [DQ_W-1:0] dq_now;
  logic [LANES-1:0] dqs_edge;
  logic last_beat;
  dcd_cmd_type dec;

  assign ck_rise = st_ff.ck_s & ~st_ff.ck_p;
  assign {cke_now, cs_n_now, ras_n_now, cas_n_now, we_n_now, ba_now, a_now} = st_ff.cp_s;
  assign {dqs_now, dm_now, dq_now} = st_ff.dp_s;
  assign dqs_edge = dqs_now ^ st_ff.dqs_p;
  assign last_beat = st_ff.push_vld && (st_ff.wr_left == 4'h0) && (st_ff.recov == 4'h0);
  // Masks are absent from the argument list, so they cannot steer decoding
  assign dec = dcd_decode(st_ff.cke_prev, cke_now, cs_n_now, ras_n_now, cas_n_now,
                          we_n_now, a_now[AP_BIT], ba_now[0], st_ff.in_sref);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ck_m = ck_i;
    nxt_st.ck_s = st_ff.ck_m;
    nxt_st.ck_p = st_ff.ck_s;
    nxt_st.cp_m = {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, bank_select_i, addr_i};
    nxt_st.cp_s = st_ff.cp_m;
    nxt_st.dp_m = {upper_data_strobe_i, lower_data_strobe_i, upper_byte_mask_i,
                   lower_byte_mask_i, dq_i};
    nxt_st.dp_s = st_ff.dp_m;
    nxt_st.dqs_p = dqs_now;
    nxt_st.cmd_vld = 1'b0;
    nxt_st.push_vld = 1'b0;
    nxt_st.overrun = st_ff.push_vld & ~beat_s.ready;

    if (ck_rise) begin
      nxt_st.cke_prev = cke_now;
      nxt_st.cmd = dec;
      // Deselect and nop produce no pulse, so chip select high is ignored
      nxt_st.cmd_vld = (dec != CMD_DESEL) && (dec != CMD_NOP);
      nxt_st.bank = ba_now;
      nxt_st.addr = a_now;
      nxt_st.all_banks = (dec == CMD_PREA);
      if (dec == CMD_SREF_ENT) begin
        nxt_st.in_sref = 1'b1;
      end else if (dec == CMD_SREF_EXIT) begin
        nxt_st.in_sref = 1'b0;
      end
      if (dec == CMD_WR || dec == CMD_WRA) begin
        nxt_st.wr_left = BURST_BEATS;
      end
    end

    // Each strobe edge carries one beat; a lane only writes if its strobe moved
    if (st_ff.wr_left != 4'h0 && dqs_edge != '0) begin
      nxt_st.push_vld = 1'b1;
      nxt_st.push_dat = {dqs_edge & ~dm_now, dq_now};
      nxt_st.wr_left = st_ff.wr_left - 4'h1;
    end

    // Hold off precharge of the written row until the last beat has settled
    if (last_beat) begin
      nxt_st.recov = WR_CYC;
    end else if (st_ff.recov != 4'h0) begin
      nxt_st.recov = st_ff.recov - 4'h1;
    end

    // Read side: strobe toggles with each word, masks play no part
    if (rd_valid_i) begin
      nxt_st.dq = rd_data_i;
      nxt_st.oe_n = 1'b0;
      nxt_st.dqs = ~st_ff.dqs;
    end else begin
      nxt_st.oe_n = 1'b1;
      nxt_st.dqs = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
      st_ff.cke_prev <= 1'b0;
      st_ff.oe_n <= 1'b1;
      st_ff.cmd <= CMD_NOP;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // Write beat buffer
  // ------------------------------------------------------------
  // A beat arriving with the buffer full is lost and flagged; the link cannot be stalled
  assign beat_s.valid = st_ff.push_vld;
  assign beat_s.data = st_ff.push_dat;
  assign word_s.ready = wr_ready_i;

  dcd_pair_buf #(.W(BEAT_W)) u_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .in_s(beat_s),
    .out_s(word_s)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign cmd_valid_o = st_ff.cmd_vld;
  assign cmd_o = st_ff.cmd;
  assign bank_o = st_ff.bank;
  assign addr_o = st_ff.addr;
  assign all_banks_o = st_ff.all_banks;
  assign mode_op_o = {st_ff.bank, st_ff.addr};
  assign self_refresh_o = st_ff.in_sref;
  assign wr_valid_o = word_s.valid;
  assign {wr_keep_o, wr_data_o} = word_s.data;
  assign wr_overrun_o = st_ff.overrun;
  assign wr_recovery_o = (st_ff.recov != 4'h0);
  assign dq_o = st_ff.dq;
  assign dq_oe_n_o = st_ff.oe_n;
  assign lower_data_strobe_o = st_ff.dqs[0];
  assign upper_data_strobe_o = st_ff.dqs[1];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i || !ce_i);

  sequence s_read_edge;
    ck_rise && st_ff.cke_prev && cke_now && !cs_n_now && ras_n_now && !cas_n_now && we_n_now;
  endsequence
  sequence s_read_out;
    cmd_valid_o && bank_o == $past(ba_now);
  endsequence

  a_read_decode_bank: assert property (s_read_edge |=> s_read_out)
    else $error("read command not decoded with its bank");
  a_deselect_ignored: assert property (ck_rise && cs_n_now && st_ff.cke_prev && cke_now
                                       |=> !cmd_valid_o)
    else $error("command taken while deselected");
  a_prea_all_banks: assert property (cmd_valid_o && cmd_o == CMD_PREA |-> all_banks_o)
    else $error("precharge all without all banks");
  a_pre_one_bank: assert property (cmd_valid_o && cmd_o == CMD_PRE
                                   |-> !all_banks_o && !addr_o[AP_BIT])
    else $error("single precharge marked as all banks");
  a_mask_drops_byte: assert property (st_ff.wr_left != 4'h0 && dqs_edge[0] && dm_now[0]
                                      |=> st_ff.push_vld && !st_ff.push_dat[DQ_W])
    else $error("masked low byte kept");
  a_upper_lane_own: assert property (st_ff.wr_left != 4'h0 && dqs_edge[1] && !dm_now[1]
                                     |=> st_ff.push_dat[DQ_W+1])
    else $error("unmasked high byte dropped");
  a_fall_edge_beat: assert property (st_ff.wr_left != 4'h0 && $fell(dqs_now[0])
                                     |=> st_ff.push_vld)
    else $error("falling strobe edge lost a beat");
  a_read_no_mask: assert property (rd_valid_i |=> !dq_oe_n_o && dq_o == $past(rd_data_i))
    else $error("read data not driven as given");
  a_read_strobe_toggle: assert property (rd_valid_i ##1 rd_valid_i
                                         |=> lower_data_strobe_o != $past(lower_data_strobe_o)
                                             && upper_data_strobe_o == lower_data_strobe_o)
    else $error("read strobe not toggling with data");
  a_write_recovery: assert property (last_beat |=> wr_recovery_o [*1] ##(WR_CYC_RAW) !wr_recovery_o)
    else $error("write recovery window wrong");
  a_powerdown_pair: assert property (ck_rise && st_ff.cke_prev && !cke_now && cs_n_now
                                     |=> cmd_valid_o && cmd_o == CMD_PD_ENT)
    else $error("power down entry not seen");

endmodule : dcd_cmd_front

// ==== dv/dcd_ctrl_model.sv ====
// Controller model: free memory clock, command pins and write bursts
`timescale 1ns/1ps
module dcd_ctrl_model (
  input wire logic clk_i,
  output logic ck_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [dcd_pkg::BANK_W-1:0] bank_select_o,
  output logic [dcd_pkg::ADDR_W-1:0] addr_o,
  output logic [dcd_pkg::DQ_W-1:0] dq_o,
  output logic lower_data_strobe_o,
  output logic upper_data_strobe_o,
  output logic lower_byte_mask_o,
  output logic upper_byte_mask_o
);
  import dcd_pkg::*;
  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Clock enable starts low, as at power up
  initial begin
    {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 5'h0F;
    {bank_select_o, addr_o, dq_o} = '0;
    {lower_data_strobe_o, upper_data_strobe_o, lower_byte_mask_o, upper_byte_mask_o} = 4'h0;
    ck_o = 1'b0;
    #7;
    forever #80 ck_o = ~ck_o;
  end
  // One command per memory clock, then a no-operation with toggling don't-care lines.
  // Pins are held for two clk_i samples after the memory clock rises, which covers the
  // synchroniser, and the task returns before the decoded pulse shows.
  task automatic issue(input logic cke, input logic cs_n, input logic [2:0] rcw,
                       input logic [1:0] ba, input logic [12:0] a);
    @(negedge ck_o);
    @(posedge clk_i);
    #2;
    cke_o = cke;
    cs_n_o = cs_n;
    {ras_n_o, cas_n_o, we_n_o} = rcw;
    bank_select_o = ba;
    addr_o = a;
    @(posedge ck_o);
    repeat (2) @(posedge clk_i);
    #2;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
    bank_select_o = ~bank_select_o;
    addr_o = ~addr_o;
    {upper_byte_mask_o, lower_byte_mask_o} = ~{upper_byte_mask_o, lower_byte_mask_o};
  endtask : issue
  // Strobe moves two cycles after data, so it sits in the middle of the data eye
  task automatic burst(input logic [15:0] d [8], input logic [1:0] m [8]);
    foreach (d[i]) begin
      @(posedge clk_i);
      #2;
      dq_o = d[i];
      {upper_byte_mask_o, lower_byte_mask_o} = m[i];
      repeat (2) @(posedge clk_i);
      #2;
      lower_data_strobe_o = ~lower_data_strobe_o;
      upper_data_strobe_o = ~upper_data_strobe_o;
      @(posedge clk_i);
    end
    @(posedge clk_i);
    #2;
    dq_o = ~dq_o;
  endtask : burst
endmodule : dcd_ctrl_model

// ==== dv/ddr_command_decode_write_mask_tb_top.sv ====
// Testbench: command decode, write masking and read drive against a queue model
`timescale 1ns/1ps
module ddr_command_decode_write_mask_tb_top;
  import dcd_pkg::*;
  logic clk_i, resetn_i, ck, cke, cs_n, ras_n, cas_n, we_n, lds, uds, lbm, ubm;
  logic [BANK_W-1:0] ba, bank_o;
  logic [ADDR_W-1:0] addr, addr_o;
  logic [DQ_W-1:0] dq, rd_data_i, wr_data_o, rd_dq;
  logic rd_valid_i, wr_ready_i, cmd_valid_o, all_banks_o, self_refresh_o, wr_valid_o;
  logic wr_overrun_o, wr_recovery_o, dq_oe_n_o, lds_o, uds_o, stall, tgl, sr, rd_on, m_oe, m_ls;
  logic ce;
  logic [LANES-1:0] wr_keep_o;
  logic [BANK_W+ADDR_W-1:0] mode_op_o;
  logic [DQ_W-1:0] d_q;
  dcd_cmd_type cmd_o;
  logic [17:0] exp_q [$];
  int fail_count, comparisons, ovr_cnt, rec_cnt;
  dcd_ctrl_model ctrl_inst (.clk_i(clk_i), .ck_o(ck), .cke_o(cke), .cs_n_o(cs_n),
    .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .bank_select_o(ba), .addr_o(addr),
    .dq_o(dq), .lower_data_strobe_o(lds), .upper_data_strobe_o(uds),
    .lower_byte_mask_o(lbm), .upper_byte_mask_o(ubm));
  dcd_cmd_front dcd_cmd_front_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .ck_i(ck), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
    .bank_select_i(ba), .addr_i(addr), .dq_i(dq), .lower_data_strobe_i(lds),
    .upper_data_strobe_i(uds), .lower_byte_mask_i(lbm), .upper_byte_mask_i(ubm),
    .rd_data_i(rd_data_i), .rd_valid_i(rd_valid_i), .wr_ready_i(wr_ready_i),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .bank_o(bank_o), .addr_o(addr_o),
    .all_banks_o(all_banks_o), .mode_op_o(mode_op_o), .self_refresh_o(self_refresh_o),
    .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o), .wr_keep_o(wr_keep_o),
    .wr_overrun_o(wr_overrun_o), .wr_recovery_o(wr_recovery_o), .dq_o(rd_dq),
    .dq_oe_n_o(dq_oe_n_o), .lower_data_strobe_o(lds_o), .upper_data_strobe_o(uds_o));
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  task automatic note(input logic ok, input string what);
    comparisons++;
    if (!ok) begin
      fail_count++;
      $display("ERROR %0t %s mismatch", $time, what);
    end
  endtask : note
  task automatic chk_cmd(input logic [37:0] got, input logic [37:0] exp);
    note(got === exp, "command");
  endtask : chk_cmd
  task automatic chk_wr(input logic [17:0] got, input logic [17:0] exp);
    note(got === exp, "write word");
  endtask : chk_wr
  task automatic chk_rd(input logic [18:0] got, input logic [18:0] exp);
    note(got === exp, "read word");
  endtask : chk_rd
  task automatic chk_cnt(input int got, input int exp);
    note(got == exp, "count");
  endtask : chk_cnt
  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Pulse expected for everything but deselect and no-operation; every field compared in full
  task automatic op(input logic k, input logic c, input logic [2:0] rcw, input logic ap,
                    input dcd_cmd_type e);
    logic [1:0] b;
    logic [12:0] a;
    logic seen;
    logic p;
    b = 2'($urandom);
    a = 13'($urandom);
    p = (e != CMD_NOP) && (e != CMD_DESEL);
    if (e == CMD_MODE) b[0] = 1'b0;
    if (e == CMD_EXT_MODE) b[0] = 1'b1;
    a[AP_BIT] = ap;
    seen = 1'b0;
    ctrl_inst.issue(k, c, rcw, b, a);
    for (int i = 0; i < 5 && !seen; i++) begin
      @(posedge clk_i);
      #1;
      seen = (cmd_valid_o === 1'b1);
    end
    if (e == CMD_SREF_ENT) sr = 1'b1;
    if (e == CMD_SREF_EXIT) sr = 1'b0;
    chk_cmd({seen, cmd_o, all_banks_o, mode_op_o, self_refresh_o, bank_o, addr_o},
            {p, e, e == CMD_PREA, {b, a}, sr, b, a});
  endtask : op
  task automatic write_burst(input logic hold);
    logic [15:0] d [8];
    logic [1:0] m [8];
    foreach (d[i]) begin
      d[i] = 16'($urandom);
      m[i] = 2'($urandom);
      if (!hold || i < 2) exp_q.push_back({~m[i], d[i]});
    end
    ctrl_inst.burst(d, m);
  endtask : write_burst
  // ------------------------------------------------------------
  // Clock, sinks and monitors
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Sink never stalls two cycles in a row unless held off on purpose
  always @(posedge clk_i) begin
    #2;
    tgl = ~tgl;
    wr_ready_i = !stall && (tgl || 1'($urandom));
  end
  always @(posedge clk_i) begin
    if (resetn_i && wr_valid_o && wr_ready_i) begin
      chk_wr({wr_keep_o, wr_data_o}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
    if (wr_overrun_o === 1'b1) ovr_cnt++;
    if (wr_recovery_o === 1'b1) rec_cnt++;
    if (rd_on) begin
      chk_rd({dq_oe_n_o, lds_o, uds_o, rd_dq}, {m_oe, m_ls, m_ls, d_q});
    end
    // Read model: a frozen cycle leaves every read output where it was
    if (ce) begin
      m_oe = !rd_valid_i;
      m_ls = rd_valid_i && !m_ls;
      if (rd_valid_i) d_q = rd_data_i;
    end
  end
  initial begin
    repeat (6000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  // Mode loads follow a precharge-all; no activate follows an autoprecharge
  initial begin
    {resetn_i, rd_valid_i, wr_ready_i, stall, tgl, sr, rd_on, m_ls} = '0;
    {m_oe, ce} = 2'h3;
    {rd_data_i, d_q} = '0;
    void'($urandom(32'hB15CE826));
    repeat (2) @(posedge clk_i);
    #2;
    resetn_i = 1'b1;
    op(1'b1, 1'b0, 3'h7, 1'b0, CMD_PD_EXIT);
    op(1'b1, 1'b1, 3'h3, 1'b0, CMD_DESEL);
    op(1'b1, 1'b0, 3'h7, 1'b0, CMD_NOP);
    op(1'b1, 1'b0, 3'h2, 1'b1, CMD_PREA);
    op(1'b1, 1'b0, 3'h0, 1'b0, CMD_EXT_MODE);
    op(1'b1, 1'b0, 3'h0, 1'b0, CMD_MODE);
    op(1'b1, 1'b0, 3'h1, 1'b0, CMD_AREF);
    op(1'b1, 1'b0, 3'h3, 1'b0, CMD_ACT);
    op(1'b1, 1'b0, 3'h5, 1'b0, CMD_RD);
    op(1'b1, 1'b0, 3'h5, 1'b1, CMD_RDA);
    op(1'b1, 1'b0, 3'h6, 1'b0, CMD_BST);
    op(1'b1, 1'b0, 3'h2, 1'b0, CMD_PRE);
    op(1'b1, 1'b0, 3'h4, 1'b0, CMD_WR);
    write_burst(1'b0);
    op(1'b1, 1'b0, 3'h4, 1'b1, CMD_WRA);
    // Sink held off only once the first burst has drained: two beats fit, six drop
    stall = 1'b1;
    write_burst(1'b1);
    repeat (8) @(posedge clk_i);
    #2;
    stall = 1'b0;
    repeat (8) @(posedge clk_i);
    chk_cnt(exp_q.size(), 0);
    chk_cnt(ovr_cnt, 6);
    chk_cnt(rec_cnt, 2 * int'(WR_CYC));
    op(1'b0, 1'b0, 3'h1, 1'b0, CMD_SREF_ENT);
    op(1'b0, 1'b0, 3'h7, 1'b0, CMD_NOP);
    op(1'b1, 1'b1, 3'h7, 1'b0, CMD_SREF_EXIT);
    op(1'b1, 1'b0, 3'h7, 1'b0, CMD_NOP);
    op(1'b0, 1'b1, 3'h7, 1'b0, CMD_PD_ENT);
    op(1'b1, 1'b0, 3'h7, 1'b0, CMD_PD_EXIT);
    rd_on = 1'b1;
    repeat (40) begin
      @(posedge clk_i);
      #2;
      rd_valid_i = 1'($urandom);
      rd_data_i = 16'($urandom);
      // Clock enable dropped about one cycle in four, so frozen cycles are seen
      ce = ($urandom % 4) != 0;
    end
    @(posedge clk_i);
    #2;
    rd_valid_i = 1'b0;
    ce = 1'b1;
    repeat (3) @(posedge clk_i);
    #2;
    rd_on = 1'b0;
    tally_and_finish();
  end
endmodule : ddr_command_decode_write_mask_tb_top
